// [apr_responder.sv]
//Contract
//- Device stays busy up to third second
//- Request while busy gets busy status
//- One identifier per request, one/three values
//- Reads accepted in monitor or slave state
//- Header shows old state until next transaction
//- Identifiers 1-125 analog, 128-255 digital
//- Checksum request: addr,4204,X4,id,0,cs
//- Plain request: protocol 0204, no checksum
//- Checksum field is two hex digits
//- Six character header: error,status,mode,alarm
//- Single analog reply: header,id,value,cs
//- Triple ids reply with three values
//- Value: four digits, one point, sign
//- State digit E monitor, 6 slave; 4 read
`timescale 1ns/1ps
module apr_responder #(
	parameter int BUSY_CYCLES = apr_pkg::BUSY_CYCLES,
	parameter int FIFO_DEPTH  = 32
) (
	input  wire logic        mclk,
	input  wire logic        srst,
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic [7:0]  rx_data,
	input  wire logic        rx_valid,
	output logic             rx_ready,
	output logic      [7:0]  tx_data,
	output logic             tx_valid,
	input  wire logic        tx_ready
);
	typedef struct packed {
		apr_pkg::apr_state_t       st;
		logic                      ack;
		logic [31:0]               rdata;
		logic [6:0]                own_addr;
		logic                      en;
		logic [7:0]                stat;
		logic [2:0]                mode;
		logic [3:0]                alarm;
		logic [2:0][18:0]          val;
		logic [11:0]               dig;
		logic [7:0]                tri_lo;
		logic [7:0]                tri_hi;
		logic                      monitor;
		logic [2:0]                fld;
		logic [2:0]                cnt;
		logic                      bad;
		logic [6:0]                p_addr;
		logic                      p_cs;
		logic [3:0]                p_x;
		logic [9:0]                p_id;
		logic [11:0]               p_bcd;
		apr_pkg::apr_kind_t        kind;
		logic [7:0]                r_err;
		logic                      r_cs;
		logic                      r_mon;
		logic [11:0]               r_bcd;
		logic [9:0]                last_id;
		logic [1:0]                vi;
		logic [2:0]                k;
		logic [7:0]                sum;
		apr_pkg::apr_busy_t        busy_cnt;
	} apr_st_t;

	apr_st_t          q_reg;
	apr_st_t          q_next;
	logic [7:0]       ch;
	apr_stream_if #(.W(8)) resp_in ();
	apr_stream_if #(.W(8)) resp_out ();

	function automatic logic [7:0] hex_asc(input logic [3:0] n);
		hex_asc = (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
	endfunction

	// Upper and lower case accepted
	function automatic logic [4:0] hex_val(input logic [7:0] c);
		if (c >= 8'h30 && c <= 8'h39)
			hex_val = {1'b1, c[3:0]};
		else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66))
			hex_val = {1'b1, 4'(c[3:0] + 4'h9)};
		else
			hex_val = 5'h00;
	endfunction

	function automatic logic is_dec(input logic [7:0] c);
		is_dec = (c >= 8'h30 && c <= 8'h39);
	endfunction

	// Point follows digit p; the digit index skips the point
	function automatic logic [7:0] val_char(input logic [18:0] v,
		input logic [2:0] j);
		logic [2:0]  p;
		logic [1:0]  idx;
		logic [15:0] s;
		p = {1'b0, v[apr_pkg::VAL_PT_LSB +: 2]};
		idx = (j <= p) ? j[1:0] : 2'(j - 3'd1);
		s = v[apr_pkg::VAL_BCD_LSB +: 16] << {idx, 2'b00};
		if (j == p + 3'd1)
			val_char = apr_pkg::CH_DOT;
		else
			val_char = apr_pkg::CH_ZERO + {4'h0, s[15:12]};
	endfunction

	function automatic logic field_ok(input logic [2:0] f,
		input logic [2:0] n, input logic cs);
		case (f)
			3'd0: field_ok = (n == 3'd2);
			3'd1: field_ok = (n == 3'd4);
			3'd2: field_ok = (n == 3'd2);
			3'd3: field_ok = (n == 3'd3);
			3'd4: field_ok = (n == 3'd1);
			3'd5: field_ok = (n == 3'd2) && cs;
			default: field_ok = 1'b0;
		endcase
	endfunction

	// Response bytes are queued; new requests are not taken until the queue has drained
	apr_fifo #(
		.W     (8),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.mclk (mclk),
		.srst (srst),
		.wr   (resp_in),
		.rd   (resp_out)
	);

	assign tx_data = resp_out.data;
	assign tx_valid = resp_out.valid;
	assign resp_out.ready = tx_ready;
	assign resp_in.data = ch;
	assign resp_in.valid = (q_reg.st inside {apr_pkg::ST_HDR, apr_pkg::ST_ID,
		apr_pkg::ST_VAL, apr_pkg::ST_CSUM, apr_pkg::ST_EOL});
	assign avs_waitrequest = (avs_read | avs_write) & ~q_reg.ack;
	assign avs_readdata = q_reg.rdata;
	// Listening even while busy, so late requests get the busy answer
	assign rx_ready = (q_reg.st == apr_pkg::ST_IDLE) |
		(q_reg.st == apr_pkg::ST_BUSYW);

	// Character of the response currently offered to the buffer
	always_comb
	begin
		logic [18:0] v;
		v = q_reg.val[q_reg.vi];
		ch = apr_pkg::CH_LF;
		case (q_reg.st)
			apr_pkg::ST_HDR:
				case (q_reg.k)
					3'd0: ch = hex_asc(q_reg.r_err[7:4]);
					3'd1: ch = hex_asc(q_reg.r_err[3:0]);
					3'd2: ch = hex_asc((q_reg.kind == apr_pkg::K_BUSY) ?
						apr_pkg::STAT_BUSY[7:4] : q_reg.stat[7:4]);
					3'd3: ch = hex_asc((q_reg.kind == apr_pkg::K_BUSY) ?
						apr_pkg::STAT_BUSY[3:0] : q_reg.stat[3:0]);
					3'd4: ch = hex_asc({q_reg.monitor, q_reg.mode});
					default: ch = hex_asc(q_reg.alarm);
				endcase
			apr_pkg::ST_ID:
				case (q_reg.k)
					3'd0: ch = apr_pkg::CH_COMMA;
					3'd1: ch = hex_asc(q_reg.r_bcd[11:8]);
					3'd2: ch = hex_asc(q_reg.r_bcd[7:4]);
					default: ch = hex_asc(q_reg.r_bcd[3:0]);
				endcase
			apr_pkg::ST_VAL:
				if (q_reg.k == 3'd0)
					ch = apr_pkg::CH_COMMA;
				else if (q_reg.kind == apr_pkg::K_DIGITAL)
					ch = hex_asc(q_reg.dig[4'(12 - 4 * q_reg.k) +: 4]);
				else if (q_reg.k == 3'd1)
					ch = apr_pkg::CH_MINUS;
				else
					ch = val_char(v, 3'(q_reg.k - 3'd2));
			apr_pkg::ST_CSUM:
				case (q_reg.k)
					3'd0: ch = apr_pkg::CH_COMMA;
					3'd1: ch = hex_asc(q_reg.sum[7:4]);
					default: ch = hex_asc(q_reg.sum[3:0]);
				endcase
			apr_pkg::ST_EOL:
				ch = (q_reg.k == 3'd0) ? apr_pkg::CH_CR : apr_pkg::CH_LF;
			default: ch = apr_pkg::CH_LF;
		endcase
	end

	// Register slave, parser and response sequencer
	always_comb
	begin
		logic [7:0]  c;
		logic [4:0]  hv;
		logic        good;
		logic        tail;
		apr_pkg::apr_state_t after_payload;
		c = rx_data;
		hv = hex_val(rx_data);
		good = 1'b0;
		tail = 1'b0;
		q_next = q_reg;
		after_payload = q_reg.r_cs ? apr_pkg::ST_CSUM : apr_pkg::ST_EOL;

		// One wait cycle, then the answer; reads sampled before ack
		q_next.ack = (avs_read | avs_write) & ~q_reg.ack;
		if (avs_read && !q_reg.ack)
		begin
			q_next.rdata = '0;
			if (avs_address == apr_pkg::OFS_CTRL)
			begin
				q_next.rdata[apr_pkg::CTRL_ADDR_LSB +: 7] = q_reg.own_addr;
				q_next.rdata[apr_pkg::CTRL_EN_BIT] = q_reg.en;
			end
			else if (avs_address == apr_pkg::OFS_HDR)
			begin
				q_next.rdata[apr_pkg::HDR_STAT_LSB +: 8] = q_reg.stat;
				q_next.rdata[apr_pkg::HDR_MODE_LSB +: 3] = q_reg.mode;
				q_next.rdata[apr_pkg::HDR_ALARM_LSB +: 4] = q_reg.alarm;
			end
			else if (avs_address == apr_pkg::OFS_VAL0)
				q_next.rdata[18:0] = q_reg.val[0];
			else if (avs_address == apr_pkg::OFS_VAL1)
				q_next.rdata[18:0] = q_reg.val[1];
			else if (avs_address == apr_pkg::OFS_VAL2)
				q_next.rdata[18:0] = q_reg.val[2];
			else if (avs_address == apr_pkg::OFS_DIG)
				q_next.rdata[11:0] = q_reg.dig;
			else if (avs_address == apr_pkg::OFS_TRIPLE)
				q_next.rdata[15:0] = {q_reg.tri_hi, q_reg.tri_lo};
			else if (avs_address == apr_pkg::OFS_STATUS)
			begin
				q_next.rdata[0] = (q_reg.st == apr_pkg::ST_BUSYW);
				q_next.rdata[1] = q_reg.monitor;
				q_next.rdata[2] = ~rx_ready;
				q_next.rdata[apr_pkg::STS_ID_LSB +: 10] = q_reg.last_id;
			end
		end
		if (avs_write && q_reg.ack)
		begin
			if (avs_address == apr_pkg::OFS_CTRL)
			begin
				q_next.own_addr = avs_writedata[apr_pkg::CTRL_ADDR_LSB +: 7];
				q_next.en = avs_writedata[apr_pkg::CTRL_EN_BIT];
			end
			else if (avs_address == apr_pkg::OFS_HDR)
			begin
				q_next.stat = avs_writedata[apr_pkg::HDR_STAT_LSB +: 8];
				q_next.mode = avs_writedata[apr_pkg::HDR_MODE_LSB +: 3];
				q_next.alarm = avs_writedata[apr_pkg::HDR_ALARM_LSB +: 4];
			end
			else if (avs_address == apr_pkg::OFS_VAL0)
				q_next.val[0] = avs_writedata[18:0];
			else if (avs_address == apr_pkg::OFS_VAL1)
				q_next.val[1] = avs_writedata[18:0];
			else if (avs_address == apr_pkg::OFS_VAL2)
				q_next.val[2] = avs_writedata[18:0];
			else if (avs_address == apr_pkg::OFS_DIG)
				q_next.dig = avs_writedata[11:0];
			else if (avs_address == apr_pkg::OFS_TRIPLE)
			begin
				q_next.tri_lo = avs_writedata[apr_pkg::TRI_LO_LSB +: 8];
				q_next.tri_hi = avs_writedata[apr_pkg::TRI_HI_LSB +: 8];
			end
		end

		// Parser: malformed lines are dropped silently at LF
		if (rx_valid && rx_ready)
		begin
			if (c == apr_pkg::CH_LF)
			begin
				good = !q_reg.bad && q_reg.en &&
					(q_reg.fld == (q_reg.p_cs ? 3'd6 : 3'd5)) &&
					(q_reg.p_addr == q_reg.own_addr);
				q_next.fld = '0;
				q_next.cnt = '0;
				q_next.bad = 1'b0;
				q_next.p_addr = '0;
				q_next.p_id = '0;
				q_next.p_bcd = '0;
			end
			else if (c == apr_pkg::CH_COMMA || c == apr_pkg::CH_CR)
			begin
				if (q_reg.cnt == '0 && q_reg.fld >= 3'd5)
					q_next.fld = q_reg.fld;
				else if (field_ok(q_reg.fld, q_reg.cnt, q_reg.p_cs))
				begin
					q_next.fld = q_reg.fld + 3'd1;
					q_next.cnt = '0;
				end
				else
					q_next.bad = 1'b1;
			end
			else if (c != apr_pkg::CH_SP)
			begin
				q_next.cnt = (q_reg.cnt == 3'd7) ? 3'd7 : q_reg.cnt + 3'd1;
				case (q_reg.fld)
					3'd0:
						if (is_dec(c))
							q_next.p_addr = 7'(q_reg.p_addr * 7'd10 + 7'(c[3:0]));
						else
							q_next.bad = 1'b1;
					3'd1:
						if (q_reg.cnt == 3'd0 && c == apr_pkg::CH_FOUR)
							q_next.p_cs = 1'b1;
						else if (q_reg.cnt == 3'd0 && c == apr_pkg::CH_ZERO)
							q_next.p_cs = 1'b0;
						else if (!((q_reg.cnt == 3'd1 && c == apr_pkg::CH_TWO) ||
							(q_reg.cnt == 3'd2 && c == apr_pkg::CH_ZERO) ||
							(q_reg.cnt == 3'd3 && c == apr_pkg::CH_FOUR)))
							q_next.bad = 1'b1;
					3'd2:
						if (q_reg.cnt == 3'd0 && hv[4])
							q_next.p_x = hv[3:0];
						else if (!(q_reg.cnt == 3'd1 && c == apr_pkg::CH_FOUR))
							q_next.bad = 1'b1;
					3'd3:
						if (is_dec(c))
						begin
							q_next.p_id = 10'(q_reg.p_id * 10'd10 + 10'(c[3:0]));
							q_next.p_bcd = {q_reg.p_bcd[7:0], c[3:0]};
						end
						else
							q_next.bad = 1'b1;
					3'd4:
						q_next.bad = q_reg.bad | (c != apr_pkg::CH_ZERO);
					3'd5:
						q_next.bad = q_reg.bad | ~hv[4] | ~q_reg.p_cs;
					default: q_next.bad = 1'b1;
				endcase
			end
		end

		// Accepted request: busy answer or classified read
		if (good)
		begin
			q_next.r_cs = q_reg.p_cs;
			q_next.r_bcd = q_reg.p_bcd;
			q_next.r_mon = q_reg.p_x[3];
			q_next.r_err = apr_pkg::ERR_NONE;
			q_next.st = apr_pkg::ST_HDR;
			q_next.k = '0;
			q_next.vi = '0;
			q_next.sum = '0;
			if (q_reg.st == apr_pkg::ST_BUSYW)
				q_next.kind = apr_pkg::K_BUSY;
			else
			begin
				q_next.last_id = q_reg.p_id;
				if (q_reg.p_id >= apr_pkg::ANA_ID_MIN &&
					q_reg.p_id <= apr_pkg::ANA_ID_MAX)
					q_next.kind = (q_reg.p_id >= {2'b00, q_reg.tri_lo} &&
						q_reg.p_id <= {2'b00, q_reg.tri_hi}) ?
						apr_pkg::K_TRIPLE : apr_pkg::K_SINGLE;
				else if (q_reg.p_id >= apr_pkg::DIG_ID_MIN &&
					q_reg.p_id <= apr_pkg::DIG_ID_MAX)
					q_next.kind = apr_pkg::K_DIGITAL;
				else
				begin
					q_next.kind = apr_pkg::K_BADID;
					q_next.r_err = apr_pkg::ERR_BAD_ID;
				end
			end
		end

		// Sequencer advances only when the buffer takes the byte
		if (resp_in.valid && resp_in.ready)
		begin
			if (q_reg.st != apr_pkg::ST_CSUM)
				q_next.sum = q_reg.sum + ch;
			q_next.k = q_reg.k + 3'd1;
			case (q_reg.st)
				apr_pkg::ST_HDR:
					if (q_reg.k == 3'd5)
					begin
						q_next.k = '0;
						q_next.st = (q_reg.kind == apr_pkg::K_BUSY) ?
							after_payload : apr_pkg::ST_ID;
					end
				apr_pkg::ST_ID:
					if (q_reg.k == 3'd3)
					begin
						q_next.k = '0;
						q_next.st = (q_reg.kind == apr_pkg::K_BADID) ?
							after_payload : apr_pkg::ST_VAL;
					end
				apr_pkg::ST_VAL:
				begin
					if (q_reg.k == 3'd0 && q_reg.kind != apr_pkg::K_DIGITAL &&
						!q_reg.val[q_reg.vi][apr_pkg::VAL_NEG_BIT])
						q_next.k = 3'd2;
					if (q_reg.kind == apr_pkg::K_DIGITAL)
						tail = (q_reg.k == 3'd3);
					else
						tail = (q_reg.k == 3'd6);
					if (tail && q_reg.kind == apr_pkg::K_TRIPLE &&
						q_reg.vi != 2'd2)
					begin
						q_next.k = '0;
						q_next.vi = q_reg.vi + 2'd1;
					end
					else if (tail)
					begin
						q_next.k = '0;
						q_next.st = after_payload;
					end
				end
				apr_pkg::ST_CSUM:
					if (q_reg.k == 3'd2)
					begin
						q_next.k = '0;
						q_next.st = apr_pkg::ST_EOL;
					end
				apr_pkg::ST_EOL:
					if (q_reg.k == 3'd1)
					begin
						q_next.k = '0;
						q_next.st = apr_pkg::ST_DRAIN;
						// New state shows from the next reply on
						if (q_reg.kind != apr_pkg::K_BUSY)
							q_next.monitor = q_reg.r_mon;
					end
				default: q_next.k = q_reg.k;
			endcase
		end

		// Busy window starts once the last byte has left
		if (q_reg.st == apr_pkg::ST_DRAIN && !resp_out.valid)
		begin
			q_next.st = apr_pkg::ST_BUSYW;
			if (q_reg.kind != apr_pkg::K_BUSY)
				q_next.busy_cnt = apr_pkg::apr_busy_t'(BUSY_CYCLES - 1);
		end
		else if (q_reg.st == apr_pkg::ST_BUSYW && !good)
		begin
			if (q_reg.busy_cnt == '0)
				q_next.st = apr_pkg::ST_IDLE;
			else
				q_next.busy_cnt = q_reg.busy_cnt - 1'b1;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			q_reg <= '0;
			q_reg.own_addr <= apr_pkg::CTRL_ADDR_RST;
			q_reg.en <= apr_pkg::CTRL_EN_RST;
			q_reg.monitor <= apr_pkg::MONITOR_RST;
		end
		else
			q_reg <= q_next;
	end
endmodule

// [apr_pkg.sv]
package apr_pkg;
	// Timing
	localparam int          CLK_PERIOD_NS = 10;
	localparam longint      BUSY_TIME_NS  = 64'd333333333;
	localparam int          BUSY_CYCLES   = int'(BUSY_TIME_NS / CLK_PERIOD_NS);
	typedef logic [25:0]    apr_busy_t;

	// Register byte offsets
	localparam logic [4:0]  OFS_CTRL   = 5'h00;
	localparam logic [4:0]  OFS_HDR    = 5'h04;
	localparam logic [4:0]  OFS_VAL0   = 5'h08;
	localparam logic [4:0]  OFS_VAL1   = 5'h0c;
	localparam logic [4:0]  OFS_VAL2   = 5'h10;
	localparam logic [4:0]  OFS_DIG    = 5'h14;
	localparam logic [4:0]  OFS_TRIPLE = 5'h18;
	localparam logic [4:0]  OFS_STATUS = 5'h1c;

	// Field positions
	localparam int          CTRL_ADDR_LSB = 0;
	localparam int          CTRL_EN_BIT   = 8;
	localparam int          HDR_STAT_LSB  = 0;
	localparam int          HDR_MODE_LSB  = 8;
	localparam int          HDR_ALARM_LSB = 12;
	localparam int          VAL_BCD_LSB   = 0;
	localparam int          VAL_PT_LSB    = 16;
	localparam int          VAL_NEG_BIT   = 18;
	localparam int          VAL_W         = 19;
	localparam int          TRI_LO_LSB    = 0;
	localparam int          TRI_HI_LSB    = 8;
	localparam int          STS_ID_LSB    = 16;

	// Reset values
	localparam logic [6:0]  CTRL_ADDR_RST = 7'h01;
	localparam logic        CTRL_EN_RST   = 1'b1;
	localparam logic        MONITOR_RST   = 1'b1;

	// Identifier ranges
	localparam logic [9:0]  ANA_ID_MIN = 10'h001;
	localparam logic [9:0]  ANA_ID_MAX = 10'h07d;
	localparam logic [9:0]  DIG_ID_MIN = 10'h080;
	localparam logic [9:0]  DIG_ID_MAX = 10'h0ff;

	// Header codes
	localparam logic [7:0]  ERR_NONE   = 8'h00;
	localparam logic [7:0]  ERR_BAD_ID = 8'h01;
	localparam logic [7:0]  STAT_BUSY  = 8'h01;

	// Characters
	localparam logic [7:0]  CH_COMMA = 8'h2c;
	localparam logic [7:0]  CH_CR    = 8'h0d;
	localparam logic [7:0]  CH_LF    = 8'h0a;
	localparam logic [7:0]  CH_SP    = 8'h20;
	localparam logic [7:0]  CH_MINUS = 8'h2d;
	localparam logic [7:0]  CH_DOT   = 8'h2e;
	localparam logic [7:0]  CH_ZERO  = 8'h30;
	localparam logic [7:0]  CH_TWO   = 8'h32;
	localparam logic [7:0]  CH_FOUR  = 8'h34;

	// Response sequencer, Gray codes along the usual path
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_HDR   = 3'b001,
		ST_ID    = 3'b011,
		ST_VAL   = 3'b010,
		ST_CSUM  = 3'b110,
		ST_EOL   = 3'b111,
		ST_DRAIN = 3'b101,
		ST_BUSYW = 3'b100
	} apr_state_t;

	typedef enum logic [2:0] {
		K_SINGLE  = 3'd0,
		K_TRIPLE  = 3'd1,
		K_DIGITAL = 3'd2,
		K_BADID   = 3'd3,
		K_BUSY    = 3'd4
	} apr_kind_t;
endpackage

// [apr_stream_if.sv]
`timescale 1ns/1ps
interface apr_stream_if #(parameter int W = 8);
	logic [W-1:0] data;
	logic         valid;
	logic         ready;
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface

// [apr_fifo.sv]
`timescale 1ns/1ps
module apr_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 32
) (
	input wire logic    mclk,
	input wire logic    srst,
	apr_stream_if.snk   wr,
	apr_stream_if.src   rd
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wp;
		logic [AW-1:0]           rp;
		logic [CW-1:0]           cnt;
	} apr_fifo_st_t;

	apr_fifo_st_t q_reg;
	apr_fifo_st_t q_next;
	logic         push;
	logic         pop;

	// Honest flags straight from the count
	assign wr.ready = (q_reg.cnt != CW'(DEPTH));
	assign rd.valid = (q_reg.cnt != '0);
	assign rd.data  = q_reg.mem[q_reg.rp];
	assign push     = wr.valid & wr.ready;
	assign pop      = rd.valid & rd.ready;

	// Pointers wrap explicitly so any depth works
	always_comb
	begin
		q_next = q_reg;
		if (push)
		begin
			q_next.mem[q_reg.wp] = wr.data;
			q_next.wp = (q_reg.wp == AW'(DEPTH - 1)) ? '0 : q_reg.wp + 1'b1;
		end
		if (pop)
			q_next.rp = (q_reg.rp == AW'(DEPTH - 1)) ? '0 : q_reg.rp + 1'b1;
		q_next.cnt = q_reg.cnt + CW'(push) - CW'(pop);
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
			q_reg <= '0;
		else
			q_reg <= q_next;
	end
endmodule

// [apr_host_model.sv]
`timescale 1ns/1ps
module apr_host_model (
	input  wire logic       mclk,
	output logic      [7:0] rx_data,
	output logic            rx_valid,
	input  wire logic       rx_ready,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_valid,
	output logic            tx_ready
);
	logic slow;
	initial
	begin
		slow = 1'b0;
		rx_data = 8'hff;
		rx_valid = 1'b0;
	end
	// Slow host stalls every other cycle
	always @(posedge mclk)
		tx_ready <= slow ? ~tx_ready : 1'b1;

	// Idle line shows the inverse of the last byte, never a stale copy
	task automatic send(input string s);
		for (int i = 0; i < s.len(); i++)
		begin
			rx_data <= s[i];
			rx_valid <= 1'b1;
			// Byte held until the edge that sees ready high
			do
				@(posedge mclk);
			while (rx_ready !== 1'b1);
		end
		rx_valid <= 1'b0;
		rx_data <= ~s[s.len()-1];
	endtask

	// Polls for reply bytes under a bounded wait
	task automatic recv(input int lim, output string s, output bit got);
		s = "";
		got = 1'b0;
		for (int n = 0; n < lim && !got; n++)
		begin
			@(posedge mclk);
			if ((tx_valid & tx_ready) === 1'b1)
			begin
				s = $sformatf("%s%c", s, tx_data);
				got = (tx_data == 8'h0a);
			end
		end
	endtask

	// Send at most three times, then give up
	task automatic exchange(input string q, output string r, output bit got);
		got = 1'b0;
		for (int t = 0; t < 3 && !got; t++)
		begin
			send(q);
			recv(200, r, got);
		end
	endtask
endmodule

// [apr_responder_monitor.sv]
`timescale 1ns/1ps
module apr_responder_monitor (
	input wire logic        mclk,
	input wire logic        srst,
	input wire logic [4:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic [7:0]  rx_data,
	input wire logic        rx_valid,
	input wire logic        rx_ready,
	input wire logic [7:0]  tx_data,
	input wire logic        tx_valid,
	input wire logic        tx_ready
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);
	logic [7:0] last_tx_reg;
	logic       start_reg;
	logic [3:0] lf_age_reg;
	// Last reply byte, start of line, cycles since request end
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			last_tx_reg <= 8'h00;
			start_reg <= 1'b1;
			lf_age_reg <= 4'hf;
		end
		else
		begin
			if (tx_valid && tx_ready)
			begin
				last_tx_reg <= tx_data;
				start_reg <= (tx_data == apr_pkg::CH_LF);
			end
			if (rx_valid && rx_ready && rx_data == apr_pkg::CH_LF)
				lf_age_reg <= 4'h0;
			else if (lf_age_reg != 4'hf)
				lf_age_reg <= lf_age_reg + 4'h1;
		end
	end
	a_wait_once: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest) else $error("wait too long");
	a_wait_idle: assert property (!(avs_read || avs_write)
		|-> !avs_waitrequest) else $error("wait while idle");
	a_rd_zero: assert property (avs_read && !avs_waitrequest &&
		avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0)
		else $error("misaligned read not zero");
	a_rx_hold: assert property (tx_valid |-> !rx_ready)
		else $error("request taken during reply");
	a_tx_hold: assert property (tx_valid && !tx_ready
		|=> tx_valid && $stable(tx_data)) else $error("tx byte dropped");
	a_line_end: assert property (tx_valid && tx_ready &&
		tx_data == apr_pkg::CH_LF |-> last_tx_reg == apr_pkg::CH_CR)
		else $error("LF without CR");
	a_hdr_zero: assert property (start_reg && tx_valid
		|-> tx_data == apr_pkg::CH_ZERO) else $error("bad header");
	a_reply_cause: assert property ($rose(tx_valid)
		|-> lf_age_reg <= 4'h3) else $error("reply without request");
endmodule
bind apr_responder apr_responder_monitor mon (
	.mclk(mclk), .srst(srst), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
	.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));

// [apr_responder_bench.sv]
`timescale 1ns/1ps
module apr_responder_bench;
	localparam string NL = "\015\012";
	logic        mclk = 1'b0;
	logic        srst = 1'b1;
	logic [4:0]  avs_address = 5'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [7:0]  rx_data;
	logic        rx_valid;
	logic        rx_ready;
	logic [7:0]  tx_data;
	logic        tx_valid;
	logic        tx_ready;
	int          err_count = 0;
	int          checks = 0;
	string       r;
	bit          got;
	logic [31:0] q;
	// Short busy window keeps the run brief
	apr_responder #(.BUSY_CYCLES(50), .FIFO_DEPTH(32)) uut (
		.mclk(mclk), .srst(srst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .rx_data(rx_data),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
		.tx_valid(tx_valid), .tx_ready(tx_ready));
	apr_host_model host (
		.mclk(mclk), .rx_data(rx_data), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready));
	// Clock
	always #5 mclk = ~mclk;

	task automatic cmp_w(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic cmp_s(input string n, input string e, input string g);
		checks++;
		if (g != e)
		begin
			err_count++;
			$display("[ERR] %s expected %s seen %s", n, e, g);
		end
	endtask
	// Avalon access, held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [4:0] a,
		input logic [31:0] d, output logic [31:0] rd);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		// Sampled at the rising edge, data taken where waitrequest is low
		do
			@(posedge mclk);
		while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge mclk);
	endtask
	function automatic string with_cs(input string p);
		logic [7:0] s;
		s = 8'h00;
		for (int i = 0; i < p.len(); i++)
			s = s + p[i];
		return $sformatf("%s,%02X%s", p, s, NL);
	endfunction

	task automatic t_regs;
		bus(1'b0, apr_pkg::OFS_CTRL, 32'h0, q);
		cmp_w("ctrl", 32'h00000101, q);
		bus(1'b0, apr_pkg::OFS_STATUS, 32'h0, q);
		cmp_w("status", 32'h00000002, q);
		bus(1'b0, 5'h01, 32'h0, q);
		cmp_w("misaligned", 32'h0, q);
		bus(1'b1, apr_pkg::OFS_HDR, 32'h00000400, q);
		bus(1'b1, apr_pkg::OFS_VAL0, 32'h00020050, q);
		bus(1'b1, apr_pkg::OFS_VAL1, 32'h00051234, q);
		bus(1'b1, apr_pkg::OFS_VAL2, 32'h00039999, q);
		bus(1'b1, apr_pkg::OFS_DIG, 32'h00000002, q);
		bus(1'b1, apr_pkg::OFS_TRIPLE, 32'h00000505, q);
		bus(1'b0, apr_pkg::OFS_HDR, 32'h0, q);
		cmp_w("hdr", 32'h00000400, q);
		$display("t_regs done");
	endtask
	// Slave request still reports monitor, busy reply shows slave
	task automatic t_state_busy;
		host.exchange({"01,0204,64,001,0", NL}, r, got);
		cmp_s("single", {"0000C0,001,005.0", NL}, r);
		host.send({"01,0204,E4,001,0", NL});
		host.recv(200, r, got);
		cmp_s("busy", {"000140", NL}, r);
		repeat (80) @(posedge mclk);
		$display("t_state_busy done");
	endtask
	task automatic t_triple;
		host.slow <= 1'b1;
		host.exchange({"01,4204,64,005,0,a5", NL}, r, got);
		cmp_s("triple", with_cs("000040,005,005.0,-12.34,9999."), r);
		host.slow <= 1'b0;
		repeat (80) @(posedge mclk);
		$display("t_triple done");
	endtask
	task automatic t_digital;
		host.exchange({"02,0204,E4,128,0", NL}, r, got);
		cmp_w("silent", 32'h0, {31'h0, got});
		host.exchange({"01,0204,64,128,0", NL}, r, got);
		cmp_s("digital", {"000040,128,002", NL}, r);
		// Gap between the ranges: error code, echoed id, no value
		repeat (80) @(posedge mclk);
		host.exchange({"01,0204,64,126,0", NL}, r, got);
		cmp_s("bad id", {"010040,126", NL}, r);
		$display("t_digital done");
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Watchdog well beyond the expected run of about a thousand cycles
	initial
	begin
		repeat (20000) @(posedge mclk);
		err_count++;
		results;
	end
	initial
	begin
		repeat (6) @(posedge mclk);
		srst <= 1'b0;
		@(posedge mclk);
		t_regs;
		t_state_busy;
		t_triple;
		t_digital;
		results;
	end
endmodule
